// file: logic/pss_status.v
// transceiver specific status register bank behind an apb slave
`timescale 1ns/1ps
`include "pss_consts.vh"
module pss_status (
    input wire clock_i,
    input wire reset_n_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output reg pready_o,
    output reg pslverr_o,
    input wire an_enable_i,
    input wire an_complete_i,
    input wire link_up_i,
    input wire mdix_auto_i,
    input wire downgrade_i,
    input wire energy_sleep_i,
    input wire tx_pause_i,
    input wire rx_pause_i,
    input wire polarity_rev_i,
    output reg mdix_sel_o,
    output reg [1:0] xover_mode_o
);
    wire [8:0] raw;
    wire [8:0] syn;
    wire wr_control;
    wire wr_swreset;
    wire [3:0] rd_sel;
    wire unmapped;
    reg [15:0] control_q;
    reg [1:0] xover_active_q;
    reg [15:0] status_q;
    reg [15:0] status_d;
    reg xover_d;
    reg resolved_d;
    reg [31:0] rdata_d;

    assign raw = {an_enable_i, an_complete_i, link_up_i, mdix_auto_i, downgrade_i,
                  energy_sleep_i, tx_pause_i, rx_pause_i, polarity_rev_i};

    pss_sync #(
        .WIDTH(9)
    ) u_sync (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .async_i(raw),
        .sync_o(syn)
    );

    pss_apb_decode u_dec (
        .psel_i(psel_i),
        .penable_i(penable_i),
        .pwrite_i(pwrite_i),
        .paddr_i(paddr_i),
        .wr_control_o(wr_control),
        .wr_swreset_o(wr_swreset),
        .rd_sel_o(rd_sel),
        .unmapped_o(unmapped)
    );

    always @*
    begin
        resolved_d = syn[7] | ~syn[8];
        case (xover_active_q)
            `PSS_XOVER_MDI: xover_d = 1'b0;
            `PSS_XOVER_MDIX: xover_d = 1'b1;
            default: xover_d = syn[5];
        endcase
        status_d = `PSS_RST_STATUS;
        status_d[`PSS_BIT_RESOLVED] = resolved_d;
        status_d[`PSS_BIT_LINK] = syn[6];
        status_d[`PSS_BIT_XOVER] = xover_d & resolved_d;
        status_d[`PSS_BIT_DOWNGRADE] = syn[4];
        status_d[`PSS_BIT_SLEEP] = syn[3];
        status_d[`PSS_BIT_TX_PAUSE] = syn[2] & resolved_d;
        status_d[`PSS_BIT_RX_PAUSE] = syn[1] & resolved_d;
        status_d[`PSS_BIT_POLARITY] = syn[0];
    end

    always @*
    begin
        rdata_d = 32'h0000_0000;
        case (1'b1)
            rd_sel[0]: rdata_d = {16'h0000, status_q};
            rd_sel[1]: rdata_d = {16'h0000, control_q};
            rd_sel[2]: rdata_d = {23'h000000, syn};
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    always @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            control_q <= `PSS_RST_CONTROL;
            xover_active_q <= `PSS_XOVER_AUTO;
            status_q <= `PSS_RST_STATUS;
            prdata_o <= 32'h0000_0000;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            mdix_sel_o <= 1'b0;
            xover_mode_o <= `PSS_XOVER_AUTO;
        end
        else
        begin
            status_q <= status_d;
            mdix_sel_o <= status_d[`PSS_BIT_XOVER];
            xover_mode_o <= xover_active_q;
            if (wr_control)
            begin
                control_q <= pwdata_i[15:0];
            end
            if (wr_swreset)
            begin
                xover_active_q <= control_q[`PSS_CTL_XOVER_HI:`PSS_CTL_XOVER_LO];
            end
            pready_o <= psel_i & ~penable_i;
            pslverr_o <= psel_i & ~penable_i & unmapped;
            if (psel_i & ~penable_i & ~pwrite_i)
            begin
                prdata_o <= rdata_d;
            end
        end
    end
endmodule // pss_status

// file: logic/pss_consts.vh
// constants for the transceiver specific status register block
`ifndef PSS_CONSTS_VH
`define PSS_CONSTS_VH
`define PSS_OFF_STATUS 12'h000
`define PSS_OFF_CONTROL 12'h004
`define PSS_OFF_INPUTS 12'h008
`define PSS_OFF_SWRESET 12'h00c
`define PSS_BIT_RESOLVED 11
`define PSS_BIT_LINK 10
`define PSS_BIT_XOVER 6
`define PSS_BIT_DOWNGRADE 5
`define PSS_BIT_SLEEP 4
`define PSS_BIT_TX_PAUSE 3
`define PSS_BIT_RX_PAUSE 2
`define PSS_BIT_POLARITY 1
`define PSS_CTL_XOVER_LO 5
`define PSS_CTL_XOVER_HI 6
`define PSS_XOVER_MDI 2'h0
`define PSS_XOVER_MDIX 2'h1
`define PSS_XOVER_AUTO 2'h3
`define PSS_RST_CONTROL 16'h0060
`define PSS_RST_STATUS 16'h0000
`endif

// file: logic/pss_sync.v
// two flip-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
module pss_sync #(
    parameter WIDTH = 8
) (
    input wire clock_i,
    input wire reset_n_i,
    input wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);
    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;
    always @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            meta_q <= {WIDTH{1'b0}};
            sync_q <= {WIDTH{1'b0}};
        end
        else
        begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end
    assign sync_o = sync_q;
endmodule // pss_sync

// file: logic/pss_apb_decode.v
// apb register address decode and access strobes
`timescale 1ns/1ps
`include "pss_consts.vh"
module pss_apb_decode (
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    output wire wr_control_o,
    output wire wr_swreset_o,
    output wire [3:0] rd_sel_o,
    output wire unmapped_o
);
    function [3:0] dec;
        input [11:0] a;
        begin
            dec = 4'h0;
            if (a == `PSS_OFF_STATUS) dec = 4'h1;
            if (a == `PSS_OFF_CONTROL) dec = 4'h2;
            if (a == `PSS_OFF_INPUTS) dec = 4'h4;
            if (a == `PSS_OFF_SWRESET) dec = 4'h8;
        end
    endfunction
    wire acc;
    wire [3:0] hit;
    assign acc = psel_i & penable_i;
    assign hit = dec(paddr_i);
    assign wr_control_o = acc & pwrite_i & hit[1];
    assign wr_swreset_o = acc & pwrite_i & hit[3];
    assign rd_sel_o = hit;
    assign unmapped_o = (hit == 4'h0);
endmodule // pss_apb_decode

// file: bench/pss_status_properties.sv
// port assertions for the status register block
`timescale 1ns/1ps
module pss_status_properties (input wire clock_i, reset_n_i, psel_i, penable_i, pwrite_i, pready_o, an_enable_i,
    an_complete_i, mdix_sel_o, input wire [11:0] paddr_i, input wire [31:0] prdata_o, input wire [1:0] xover_mode_o);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    wire rd0 = pready_o && !pwrite_i && paddr_i == 12'h000;
    wire open_an = an_enable_i && !an_complete_i;
    property p_gate; open_an[*6] |-> !mdix_sel_o; endproperty
    a_gate: assert property (p_gate) else $error("crossover shown early");
    property p_res; (!an_enable_i)[*6] ##0 rd0 |-> prdata_o[11]; endproperty
    a_res: assert property (p_res) else $error("resolved bit low");
    property p_man; (!an_enable_i && $stable(xover_mode_o))[*6] ##0 !xover_mode_o[1] |-> mdix_sel_o == xover_mode_o[0];
    endproperty
    a_man: assert property (p_man) else $error("manual crossover wrong");
    property p_swr; $changed(xover_mode_o) |-> $past(psel_i && penable_i && pwrite_i && paddr_i == 12'h00c, 2);
    endproperty
    a_swr: assert property (p_swr) else $error("mode changed without reset");
    property p_pau; open_an[*6] ##0 rd0 |-> prdata_o[3:2] == 2'h0; endproperty
    a_pau: assert property (p_pau) else $error("pause bits early");
    property p_rsv; rd0 |-> prdata_o[9:7] == 3'h0 && prdata_o[31:12] == 20'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits set");
endmodule // pss_status_properties
bind pss_status pss_status_properties u_props (.*);

// file: bench/pss_mgmt_model.sv
// apb master standing in for the management controller
`timescale 1ns/1ps
module pss_mgmt_model (input wire clock_i, pready_o, pslverr_o, input wire [31:0] prdata_o,
    output reg psel_i, penable_i, pwrite_i, output reg [11:0] paddr_i, output reg [31:0] pwdata_i);
    reg err = 0, hung = 0;
    initial {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = 0;
    task xfer(input w, input [11:0] a, input [31:0] d, output [31:0] r);
        integer n;
        begin
            @(posedge clock_i);
            psel_i <= 1'b1;
            pwrite_i <= w;
            paddr_i <= a;
            pwdata_i <= d;
            @(posedge clock_i);
            penable_i <= 1'b1;
            n = 0;
            @(posedge clock_i);
            while (!pready_o && n < 16)
            begin
                @(posedge clock_i);
                n = n + 1;
            end
            hung = hung | !pready_o;
            r = prdata_o;
            err = pslverr_o;
            psel_i <= 1'b0;
            penable_i <= 1'b0;
        end
    endtask
endmodule // pss_mgmt_model

// file: bench/phy_status_register_bits_test.sv
// self-checking bench for the status register block
`timescale 1ns/1ps
module phy_status_register_bits_test;
    reg clock_i = 0, reset_n_i = 0, an_enable_i, an_complete_i, link_up_i, mdix_auto_i, downgrade_i;
    reg energy_sleep_i, tx_pause_i, rx_pause_i, polarity_rev_i;
    reg [31:0] lfsr = 32'h215f8d30, rd, v, exp;
    integer failures = 0, total_checks = 0, i, ctl = 3, fm = 3, res;
    wire psel_i, penable_i, pwrite_i, pready_o, pslverr_o, mdix_sel_o;
    wire [11:0] paddr_i;
    wire [31:0] pwdata_i, prdata_o;
    wire [1:0] xover_mode_o;
    always #20 clock_i = ~clock_i;
    pss_mgmt_model m (.*);
    pss_status dut (.*);
    function [31:0] lfsr_next(input [31:0] s);
        lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task drive(input [8:0] p);
        {an_enable_i, an_complete_i, link_up_i, mdix_auto_i, downgrade_i, energy_sleep_i, tx_pause_i, rx_pause_i,
            polarity_rev_i} <= p;
    endtask
    task chk(input [31:0] got, input [31:0] want);
        begin
            total_checks = total_checks + 1;
            if (got !== want)
            begin
                failures = failures + 1;
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, want);
            end
        end
    endtask
    task end_sim;
        begin
            failures = failures + m.hung;
            $display("checks=%0d failures=%0d", total_checks, failures);
            if (failures == 0 && total_checks > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    initial
    begin
        drive(9'h0);
        repeat (8) @(posedge clock_i);
        reset_n_i <= 1'b1;
        chk({30'h0, xover_mode_o}, 3);
        m.xfer(0, 12'h004, 0, rd);
        chk(rd, 32'h60);
        for (i = 0; i < 24; i = i + 1)
        begin
            lfsr = lfsr_next(lfsr);
            v = lfsr;
            drive(v[8:0]);
            m.xfer(1, 12'h004, {25'h0, v[10:9], 5'h0}, rd);
            ctl = v[10:9];
            chk({30'h0, xover_mode_o}, fm);
            if (v[11])
            begin
                m.xfer(1, 12'h00c, v, rd);
                fm = ctl;
            end
            repeat (5) @(posedge clock_i);
            res = !v[8] | v[7];
            exp = res << 11 | v[6] << 10 | (res & (fm[1] ? v[5] : fm[0])) << 6 | v[4] << 5 | v[3] << 4
                | (res & v[2]) << 3 | (res & v[1]) << 2 | v[0] << 1;
            m.xfer(0, 12'h000, 0, rd);
            chk(rd, exp);
            chk(mdix_sel_o, exp[6]);
            chk(m.err, 0);
            m.xfer(0, 12'h008, 0, rd);
            chk(rd, {23'h0, v[8:0]});
        end
        m.xfer(0, 12'h010, 0, rd);
        chk(rd, 0);
        chk(m.err, 1);
        $display("test random_status done");
        end_sim;
    end
    initial
    begin
        #400000;
        failures = failures + 1;
        end_sim;
    end
endmodule // phy_status_register_bits_test
